// ### hdl/pin_input_filter.sv
module pin_input_filter (
   input  wire logic        clk,     // system clock
   input  wire logic        rst_n,   // synchronous reset, active low
   input  wire logic [15:0] raw,     // asynchronous pin levels
   output logic      [15:0] filt     // settled pin levels
);

   logic [15:0] s1;
   logic [15:0] s2;
   logic [15:0] s3;

   // s1 is read only by s2 to keep metastability contained
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1 <= port_b_mux_pkg::SYNC_RESET;
         s2 <= port_b_mux_pkg::SYNC_RESET;
         s3 <= port_b_mux_pkg::SYNC_RESET;
      end
      else
      begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts only once two later stages agree
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         filt <= port_b_mux_pkg::SYNC_RESET;
      else
         filt <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
   end

endmodule : pin_input_filter

// ### hdl/port_b_mux_pkg.sv
package port_b_mux_pkg;

   localparam int          PIN_COUNT     = 16;
   localparam int          FIELD_W       = 2;
   // both registers share one bus word: high pins on lanes 1..0, low pins on lanes 3..2
   localparam logic [31:0] HI_SEL_ADDR   = 32'h05ffffcc;
   localparam logic [31:0] LO_SEL_ADDR   = 32'h05ffffce;
   localparam logic [15:0] SEL_RESET     = 16'h0000;
   localparam logic [15:0] READ_PAD      = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam logic [15:0] SYNC_RESET    = 16'h0000;
   localparam logic        IRQ_IDLE      = 1'b1;
   localparam logic        SERIAL_IDLE   = 1'b1;
   localparam logic        TCLK_IDLE     = 1'b0;
   localparam logic        AUX_IDLE      = 1'b0;
   localparam logic [15:0] AUX_ENABLE_DEFAULT = 16'h0000;

   typedef enum logic [1:0] {
      FUNC_GPIO    = 2'b00,
      FUNC_ALT_A   = 2'b01,
      FUNC_ALT_B   = 2'b10,
      FUNC_PATTERN = 2'b11
   } pin_func_t;

   typedef enum logic [3:0] {
      K_GPIO    = 4'h0,
      K_IRQ     = 4'h1,
      K_SCK     = 4'h2,
      K_TXD     = 4'h3,
      K_RXD     = 4'h4,
      K_TCLK    = 4'h5,
      K_TOC     = 4'h6,
      K_PATTERN = 4'h7,
      K_AUX     = 4'h8,
      K_NONE    = 4'h9
   } pin_kind_t;

   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
   } pin_drive_t;

endpackage : port_b_mux_pkg

// ### hdl/port_b_pin_function_select.sv
// How it works
// R1 - pin 15: gpio, ext_interrupt_7, reserved, pattern
// R2 - pin 14: gpio, ext_interrupt_6, reserved, pattern
// R3 - pin 13: gpio, ext_interrupt_5, serial1 clock, pattern
// R4 - pin 12: gpio, ext_interrupt_4, serial0 clock, pattern
// R5 - pin 11: gpio, reserved, serial1 transmit, pattern
// R6 - pin 10: gpio, reserved, serial1 receive, pattern
// R7 - pin 9: gpio, reserved, serial0 transmit, pattern
// R8 - pin 8: gpio, reserved, serial0 receive, pattern
// R9 - high register resets zero, fully read/write
// R10 - pin 7: gpio, timer clock d, compare b4
// R11 - pin 6: gpio, timer clock c, compare a4
// R12 - pin 5: gpio or pattern, 01 reserved
// R13 - pin 4: gpio or pattern, 01 reserved
// R14 - pin 3: gpio or pattern, 01 reserved
// R15 - low register resets zero, fully read/write
// R16 - high register at its address, byte/half/word
// R17 - reserved code keeps pin on gpio
// R18 - unknown codes stored, routing by parameter
module port_b_pin_function_select #(
   parameter logic [15:0] AUX_ENABLE = port_b_mux_pkg::AUX_ENABLE_DEFAULT
) (
   input  wire logic                       CLK_SYS,          // 125 MHz system clock
   input  wire logic                       RST_N,            // sync reset, active low
   input  wire logic                       CYC_I,            // wishbone cycle
   input  wire logic                       STB_I,            // wishbone strobe
   input  wire logic                       WE_I,             // wishbone write
   input  wire logic [31:0]                ADR_I,            // wishbone byte address
   input  wire logic [31:0]                DAT_I,            // wishbone write data
   input  wire logic [3:0]                 SEL_I,            // wishbone byte selects
   output logic      [31:0]                DAT_O,            // wishbone read data
   output logic                            ACK_O,            // wishbone acknowledge
   input  wire logic [15:0]                PIN_IN,           // package pin levels
   output port_b_mux_pkg::pin_drive_t      PIN_DRV,          // package pin drive
   input  wire port_b_mux_pkg::pin_drive_t GPIO_DRV,         // gpio drive request
   output logic      [15:0]                GPIO_IN,          // filtered pin levels
   input  wire logic [15:0]                PATTERN_BITS,     // timing pattern bits
   output logic      [3:0]                 EXT_INTERRUPT_N,  // irq 7..4, low active
   input  wire logic [1:0]                 SERIAL_CLOCK_OUT, // serial clock drive
   input  wire logic [1:0]                 SERIAL_CLOCK_OE,  // serial clock enable
   output logic      [1:0]                 SERIAL_CLOCK_IN,  // serial clock from pin
   input  wire logic [1:0]                 SERIAL_TRANSMIT,  // serial transmit data
   output logic      [1:0]                 SERIAL_RECEIVE,   // serial receive data
   input  wire logic [1:0]                 TIMER_COMPARE,    // compare b4, a4
   output logic      [1:0]                 TIMER_EXT_CLOCK,  // timer clock d, c
   input  wire port_b_mux_pkg::pin_drive_t AUX_DRV,          // spare function drive
   output logic      [15:0]                AUX_IN            // spare function input
);

   logic [15:0]               sel_hi;
   logic [15:0]               sel_lo;
   logic [31:0]               all_sel;
   logic [15:0]               filt;
   logic [15:0]               per_out;
   logic [15:0]               per_oe;
   logic [15:0]               next_out;
   logic [15:0]               next_oe;
   logic [15:0]               next_aux;
   port_b_mux_pkg::pin_kind_t kind [16];
   logic                      bus_take;
   logic                      hit_hi;
   logic                      hit_lo;

   function automatic port_b_mux_pkg::pin_kind_t kind_of(input int pin,
                                                         input logic [1:0] code);
      port_b_mux_pkg::pin_kind_t k;
      k = port_b_mux_pkg::K_NONE;
      if (code == port_b_mux_pkg::FUNC_GPIO)
         k = port_b_mux_pkg::K_GPIO;
      else if (pin <= 2)
         // encodings unknown: spare channel or nothing
         k = AUX_ENABLE[pin] ? port_b_mux_pkg::K_AUX : port_b_mux_pkg::K_NONE;
      else if (code == port_b_mux_pkg::FUNC_PATTERN)
         k = port_b_mux_pkg::K_PATTERN;
      else if (code == port_b_mux_pkg::FUNC_ALT_A)
      begin
         // R1 irq on high pins
         if (pin >= 12)
            k = port_b_mux_pkg::K_IRQ;
         // R11 timer clocks
         else if (pin == 7 || pin == 6)
            k = port_b_mux_pkg::K_TCLK;
      end
      else
      begin
         // R3 serial clocks
         if (pin == 13 || pin == 12)
            k = port_b_mux_pkg::K_SCK;
         // R5 transmit data
         else if (pin == 11 || pin == 9)
            k = port_b_mux_pkg::K_TXD;
         // R6 receive data
         else if (pin == 10 || pin == 8)
            k = port_b_mux_pkg::K_RXD;
         // R10 compare outputs
         else if (pin == 7 || pin == 6)
            k = port_b_mux_pkg::K_TOC;
         // R18 pins 5..3 code 10
         else if (pin >= 3 && pin <= 5 && AUX_ENABLE[pin])
            k = port_b_mux_pkg::K_AUX;
      end
      return k;
   endfunction : kind_of

   // R16 one word, byte lanes pick the register
   assign bus_take = CYC_I && STB_I && !ACK_O;
   assign hit_hi   = ADR_I[31:2] == port_b_mux_pkg::HI_SEL_ADDR[31:2];
   assign hit_lo   = ADR_I[31:2] == port_b_mux_pkg::LO_SEL_ADDR[31:2];

   // R9 high register storage
   select_reg u_sel_hi (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .wr    (bus_take && WE_I && hit_hi),
      .be    (SEL_I[1:0]),
      .wdata (DAT_I[15:0]),
      .value (sel_hi)
   );

   // R15 low register storage
   select_reg u_sel_lo (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .wr    (bus_take && WE_I && hit_lo),
      .be    (SEL_I[3:2]),
      .wdata (DAT_I[31:16]),
      .value (sel_lo)
   );

   // one wait state, then ack drops so each access is answered once
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
         ACK_O <= 1'b0;
      else
         ACK_O <= bus_take;
   end

   // unmapped addresses still ack, reading zero, so software never hangs
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
         DAT_O <= port_b_mux_pkg::UNMAPPED_READ;
      else if (bus_take && (hit_hi || hit_lo))
         DAT_O <= {sel_lo, sel_hi};
      else if (bus_take)
         DAT_O <= port_b_mux_pkg::UNMAPPED_READ;
   end

   pin_input_filter u_filter (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .raw   (PIN_IN),
      .filt  (filt)
   );

   assign all_sel = {sel_hi, sel_lo};

   always_comb
   begin
      per_out     = 16'h0000;
      per_oe      = 16'h0000;
      per_out[13] = SERIAL_CLOCK_OUT[1];
      per_oe[13]  = SERIAL_CLOCK_OE[1];
      per_out[12] = SERIAL_CLOCK_OUT[0];
      per_oe[12]  = SERIAL_CLOCK_OE[0];
      per_out[11] = SERIAL_TRANSMIT[1];
      per_oe[11]  = 1'b1;
      per_out[9]  = SERIAL_TRANSMIT[0];
      per_oe[9]   = 1'b1;
      per_out[7]  = TIMER_COMPARE[1];
      per_oe[7]   = 1'b1;
      per_out[6]  = TIMER_COMPARE[0];
      per_oe[6]   = 1'b1;
   end

   genvar i;
   generate
      for (i = 0; i < port_b_mux_pkg::PIN_COUNT; i++)
      begin : g_pin
         assign kind[i] = kind_of(i, all_sel[port_b_mux_pkg::FIELD_W*i +:
                                             port_b_mux_pkg::FIELD_W]);
         always_comb
         begin
            next_out[i] = GPIO_DRV.out[i];
            next_oe[i]  = GPIO_DRV.oe[i];
            next_aux[i] = port_b_mux_pkg::AUX_IDLE;
            unique case (kind[i])
               // R12 pattern drive
               port_b_mux_pkg::K_PATTERN:
               begin
                  next_out[i] = PATTERN_BITS[i];
                  next_oe[i]  = 1'b1;
               end
               port_b_mux_pkg::K_SCK, port_b_mux_pkg::K_TXD, port_b_mux_pkg::K_TOC:
               begin
                  next_out[i] = per_out[i];
                  next_oe[i]  = per_oe[i];
               end
               port_b_mux_pkg::K_AUX:
               begin
                  next_out[i] = AUX_DRV.out[i];
                  next_oe[i]  = AUX_DRV.oe[i];
                  next_aux[i] = filt[i];
               end
               // R17 inputs and reserved codes leave gpio in charge
               port_b_mux_pkg::K_GPIO, port_b_mux_pkg::K_IRQ, port_b_mux_pkg::K_RXD,
               port_b_mux_pkg::K_TCLK, port_b_mux_pkg::K_NONE:
               begin
                  next_out[i] = GPIO_DRV.out[i];
                  next_oe[i]  = GPIO_DRV.oe[i];
               end
               default:
               begin
                  next_out[i] = GPIO_DRV.out[i];
                  next_oe[i]  = GPIO_DRV.oe[i];
               end
            endcase
         end
      end
   endgenerate

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         PIN_DRV <= '0;
         AUX_IN  <= 16'h0000;
         GPIO_IN <= 16'h0000;
      end
      else
      begin
         PIN_DRV.out <= next_out;
         PIN_DRV.oe  <= next_oe;
         AUX_IN      <= next_aux;
         GPIO_IN     <= filt;
      end
   end

   // unrouted peripheral inputs sit at their idle level
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         EXT_INTERRUPT_N <= {4{port_b_mux_pkg::IRQ_IDLE}};
         SERIAL_CLOCK_IN <= {2{port_b_mux_pkg::SERIAL_IDLE}};
         SERIAL_RECEIVE  <= {2{port_b_mux_pkg::SERIAL_IDLE}};
         TIMER_EXT_CLOCK <= {2{port_b_mux_pkg::TCLK_IDLE}};
      end
      else
      begin
         // R4 irq inputs 7..4
         for (int j = 0; j < 4; j++)
            EXT_INTERRUPT_N[j] <= (kind[12+j] == port_b_mux_pkg::K_IRQ) ?
                                  filt[12+j] : port_b_mux_pkg::IRQ_IDLE;
         SERIAL_CLOCK_IN[1] <= (kind[13] == port_b_mux_pkg::K_SCK) ?
                               filt[13] : port_b_mux_pkg::SERIAL_IDLE;
         SERIAL_CLOCK_IN[0] <= (kind[12] == port_b_mux_pkg::K_SCK) ?
                               filt[12] : port_b_mux_pkg::SERIAL_IDLE;
         // R8 receive data
         SERIAL_RECEIVE[1]  <= (kind[10] == port_b_mux_pkg::K_RXD) ?
                               filt[10] : port_b_mux_pkg::SERIAL_IDLE;
         SERIAL_RECEIVE[0]  <= (kind[8] == port_b_mux_pkg::K_RXD) ?
                               filt[8] : port_b_mux_pkg::SERIAL_IDLE;
         TIMER_EXT_CLOCK[1] <= (kind[7] == port_b_mux_pkg::K_TCLK) ?
                               filt[7] : port_b_mux_pkg::TCLK_IDLE;
         TIMER_EXT_CLOCK[0] <= (kind[6] == port_b_mux_pkg::K_TCLK) ?
                               filt[6] : port_b_mux_pkg::TCLK_IDLE;
      end
   end

   a_bus_ack_once: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R16
      (CYC_I && STB_I && !ACK_O) |=> ACK_O ##1 !ACK_O)
      else $error("ack not a single pulse one cycle after request");

   a_hi_write_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R9
      (bus_take && WE_I && hit_hi && SEL_I[1:0] == 2'b11) |=> sel_hi == $past(DAT_I[15:0]))
      else $error("high select register did not store write data");

   a_reset_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R15
      $rose(RST_N) |-> (sel_hi == 16'h0000 && sel_lo == 16'h0000 && PIN_DRV == '0 && !ACK_O))
      else $error("select registers not clear after reset");

   a_pin15_pattern: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R1
      (sel_hi[15:14] == 2'b11) |=> (PIN_DRV.oe[15] && PIN_DRV.out[15] == $past(PATTERN_BITS[15])))
      else $error("pin 15 not driving pattern bit");

   a_pin14_reserved: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R2
      (sel_hi[13:12] == 2'b10) |=> (PIN_DRV.oe[14] == $past(GPIO_DRV.oe[14])
                                    && PIN_DRV.out[14] == $past(GPIO_DRV.out[14])))
      else $error("pin 14 reserved code left gpio");

   a_pin13_clock: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R3
      (sel_hi[11:10] == 2'b10) |=> (PIN_DRV.oe[13] == $past(SERIAL_CLOCK_OE[1])
                                    && SERIAL_CLOCK_IN[1] == $past(filt[13])))
      else $error("pin 13 not on serial 1 clock");

   a_pin12_irq: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R4
      (sel_hi[9:8] == 2'b01) |=> EXT_INTERRUPT_N[0] == $past(filt[12]))
      else $error("pin 12 not feeding interrupt 4");

   a_pin11_transmit: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
      (sel_hi[7:6] == 2'b10) |=> (PIN_DRV.oe[11] && PIN_DRV.out[11] == $past(SERIAL_TRANSMIT[1])))
      else $error("pin 11 not driving serial 1 transmit");

   a_pin10_receive: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
      (sel_hi[5:4] != 2'b10) |=> SERIAL_RECEIVE[1] == port_b_mux_pkg::SERIAL_IDLE)
      else $error("serial 1 receive not idle while unrouted");

   a_pin9_transmit: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R7
      (sel_hi[3:2] == 2'b10) |=> (PIN_DRV.oe[9] && PIN_DRV.out[9] == $past(SERIAL_TRANSMIT[0])))
      else $error("pin 9 not driving serial 0 transmit");

   a_pin8_receive: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
      (sel_hi[1:0] == 2'b10) |=> SERIAL_RECEIVE[0] == $past(filt[8]))
      else $error("pin 8 not feeding serial 0 receive");

   a_pin7_compare: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R10
      (sel_lo[15:14] == 2'b10) |=> (PIN_DRV.oe[7] && PIN_DRV.out[7] == $past(TIMER_COMPARE[1])))
      else $error("pin 7 not driving compare b4");

   a_pin6_tclk: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R11
      (sel_lo[13:12] == 2'b01) |=> TIMER_EXT_CLOCK[0] == $past(filt[6]))
      else $error("pin 6 not feeding timer clock c");

   a_pin5_pattern: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R12
      (sel_lo[11:10] == 2'b11) |=> (PIN_DRV.oe[5] && PIN_DRV.out[5] == $past(PATTERN_BITS[5])))
      else $error("pin 5 not driving pattern bit");

   a_pin4_reserved: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R13
      (sel_lo[9:8] == 2'b01) |=> PIN_DRV.oe[4] == $past(GPIO_DRV.oe[4]))
      else $error("pin 4 reserved code left gpio");

   a_pin3_pattern: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R14
      (sel_lo[7:6] == 2'b11) |=> PIN_DRV.out[3] == $past(PATTERN_BITS[3]))
      else $error("pin 3 not driving pattern bit");

   a_aux_gated: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R18
      (sel_lo[1:0] != 2'b00 && !AUX_ENABLE[0]) |=> (AUX_IN[0] == port_b_mux_pkg::AUX_IDLE
                                                   && PIN_DRV.oe[0] == $past(GPIO_DRV.oe[0])))
      else $error("spare input routed while disabled");

endmodule : port_b_pin_function_select

// ### hdl/select_reg.sv
module select_reg (
   input  wire logic        clk,     // system clock
   input  wire logic        rst_n,   // synchronous reset, active low
   input  wire logic        wr,      // write strobe
   input  wire logic [1:0]  be,      // byte enables
   input  wire logic [15:0] wdata,   // write data
   output logic      [15:0] value    // stored select fields
);

   genvar b;
   generate
      for (b = 0; b < 2; b++)
      begin : g_byte
         always_ff @(posedge clk)
         begin
            if (!rst_n)
               value[8*b +: 8] <= port_b_mux_pkg::SEL_RESET[8*b +: 8];
            else if (wr && be[b])
               value[8*b +: 8] <= wdata[8*b +: 8];
         end
      end
   endgenerate

endmodule : select_reg

// ### tb/pin_side_model.sv
module pin_side_model (
   input  wire port_b_mux_pkg::pin_drive_t drv,   // pin drive from the block
   input  wire logic [15:0]                ext,   // level set by the outside world
   output logic      [15:0]                pins   // resolved pin levels
);
   timeunit 1ns;
   timeprecision 1ps;

   // a released pin shows the outside level, never the last driven one
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         pins[i] = drv.oe[i] ? drv.out[i] : ext[i];
      end
   end
endmodule : pin_side_model

// ### tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] HI_ADR  = port_b_mux_pkg::HI_SEL_ADDR;
   localparam logic [31:0] LO_ADR  = port_b_mux_pkg::LO_SEL_ADDR;
   localparam logic [31:0] UNM_ADR = HI_ADR + 32'h0000_0004;

   logic                       clk;
   logic                       rst_n;
   logic                       cyc;
   logic                       stb;
   logic                       we;
   logic [31:0]                adr;
   logic [31:0]                dat_w;
   logic [3:0]                 sel;
   logic [31:0]                dat_r;
   logic                       ack;
   logic [15:0]                pin_in;
   port_b_mux_pkg::pin_drive_t pin_drv;
   port_b_mux_pkg::pin_drive_t gpio_drv;
   logic [15:0]                gpio_in;
   logic [15:0]                pattern;
   logic [3:0]                 irq_n;
   logic [1:0]                 sck_out;
   logic [1:0]                 sck_oe;
   logic [1:0]                 sck_in;
   logic [1:0]                 ser_tx;
   logic [1:0]                 ser_rx;
   logic [1:0]                 tmr_cmp;
   logic [1:0]                 tmr_clk;
   port_b_mux_pkg::pin_drive_t aux_drv;
   logic [15:0]                aux_in;
   logic [15:0]                ext;
   int                         failures;
   int                         compares;
   logic [31:0]                codes [2];

   port_b_pin_function_select port_b_pin_function_select_inst (
      .CLK_SYS(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .DAT_I(dat_w), .SEL_I(sel), .DAT_O(dat_r), .ACK_O(ack), .PIN_IN(pin_in),
      .PIN_DRV(pin_drv), .GPIO_DRV(gpio_drv), .GPIO_IN(gpio_in), .PATTERN_BITS(pattern),
      .EXT_INTERRUPT_N(irq_n), .SERIAL_CLOCK_OUT(sck_out), .SERIAL_CLOCK_OE(sck_oe),
      .SERIAL_CLOCK_IN(sck_in), .SERIAL_TRANSMIT(ser_tx), .SERIAL_RECEIVE(ser_rx),
      .TIMER_COMPARE(tmr_cmp), .TIMER_EXT_CLOCK(tmr_clk), .AUX_DRV(aux_drv), .AUX_IN(aux_in)
   );

   pin_side_model pin_side_model_inst (.drv(pin_drv), .ext(ext), .pins(pin_in));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // request held until ack is sampled high; read data taken at that edge
   task automatic wb_cycle(input logic w, input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= s;
      do
      begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
         tally_and_finish();
      end
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb_cycle

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] v;
      wb_cycle(1'b1, a, d, s, v);
   endtask : wr

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      wb_cycle(1'b0, a, 32'h0000_0000, 4'hf, v);
      check(v, exp);
   endtask : rd_chk

   // checks read the values settled before the last edge
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask : settle

   initial
   begin
      #50us;
      failures++;
      tally_and_finish();
   end

   initial
   begin
      failures = 0;
      compares = 0;
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 32'h0000_0000;
      dat_w = 32'h0000_0000;
      sel = 4'h0;
      gpio_drv = 32'h0000_0000;
      pattern = 16'h0000;
      sck_out = 2'b00;
      sck_oe = 2'b00;
      ser_tx = 2'b00;
      tmr_cmp = 2'b00;
      aux_drv = 32'h0000_0000;
      ext = 16'h0000;
      codes[0] = 32'h057f_0000;
      codes[1] = 32'h0aaa_0000;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      settle(4);
      rd_chk(HI_ADR, 32'h0000_0000);
      rd_chk(LO_ADR, 32'h0000_0000);
      wr(HI_ADR, 32'h0000_a5c3, 4'hf);
      rd_chk(HI_ADR, 32'h0000_a5c3);
      wr(HI_ADR, 32'h0000_5a3c, 4'h1);
      rd_chk(HI_ADR, 32'h0000_a53c);
      wr(HI_ADR, 32'h0000_5a3c, 4'h2);
      rd_chk(HI_ADR, 32'h0000_5a3c);
      wr(LO_ADR, 32'hffff_ffff, 4'hc);
      rd_chk(LO_ADR, 32'hffff_5a3c);
      wr(UNM_ADR, 32'h0000_ffff, 4'hf);
      rd_chk(UNM_ADR, 32'h0000_0000);
      rd_chk(HI_ADR, 32'hffff_5a3c);
      $display("test registers done");
      gpio_drv <= 32'h1357_00ff;
      pattern <= 16'hc3a5;
      wr(HI_ADR, 32'hffc0_ffff, 4'hf);
      settle(2);
      check(pin_drv, 32'hc3a7_ffff);
      pattern <= 16'h3c5a;
      settle(2);
      check(pin_drv, 32'h3c5f_ffff);
      $display("test pattern done");
      gpio_drv <= 32'h0000_0000;
      ser_tx <= 2'b10;
      ext <= 16'h0400;
      wr(HI_ADR, 32'h0000_00aa, 4'hf);
      settle(2);
      check(pin_drv, 32'h0800_0a00);
      settle(8);
      check({30'h0, ser_rx}, 32'h0000_0002);
      ext <= 16'h0100;
      settle(8);
      check({30'h0, ser_rx}, 32'h0000_0001);
      check({16'h0, gpio_in}, 32'h0000_0900);
      $display("test serial data done");
      ext <= 16'ha000;
      wr(HI_ADR, 32'h0000_5500, 4'hf);
      settle(8);
      check({28'h0, irq_n}, 32'h0000_000a);
      gpio_drv <= 32'h8000_c000;
      wr(HI_ADR, 32'h0000_a000, 4'hf);
      settle(8);
      check(pin_drv, 32'h8000_c000);
      check({28'h0, irq_n}, 32'h0000_000f);
      gpio_drv <= 32'h0000_0000;
      sck_out <= 2'b10;
      sck_oe <= 2'b10;
      ext <= 16'h0000;
      wr(HI_ADR, 32'h0000_0a00, 4'hf);
      settle(2);
      check(pin_drv, 32'h2000_2000);
      settle(8);
      check({30'h0, sck_in}, 32'h0000_0002);
      check({28'h0, irq_n}, 32'h0000_000f);
      $display("test interrupt and clock done");
      tmr_cmp <= 2'b01;
      wr(HI_ADR, 32'h0000_0000, 4'hf);
      wr(LO_ADR, 32'ha000_0000, 4'hc);
      settle(2);
      check(pin_drv, 32'h0040_00c0);
      ext <= 16'h0080;
      wr(LO_ADR, 32'h5000_0000, 4'hc);
      settle(8);
      check(pin_drv, 32'h0000_0000);
      check({30'h0, tmr_clk}, 32'h0000_0002);
      gpio_drv <= 32'h00a5_00ff;
      pattern <= 16'hffff;
      foreach (codes[i])
      begin
         wr(LO_ADR, codes[i], 4'hc);
         settle(2);
         check(pin_drv, 32'h00a5_00ff);
         check({16'h0, aux_in}, 32'h0000_0000);
      end
      wr(HI_ADR, 32'h0000_0055, 4'h3);
      settle(8);
      check(pin_drv, 32'h00a5_00ff);
      check({30'h0, ser_rx}, 32'h0000_0003);
      $display("test timer and reserved done");
      rst_n <= 1'b0;
      settle(2);
      rst_n <= 1'b1;
      settle(4);
      check(pin_drv, 32'h00a5_00ff);
      rd_chk(HI_ADR, 32'h0000_0000);
      $display("test reset done");
      tally_and_finish();
   end
endmodule : testbench
